// ===== verilog/fpes_pkg.sv
// Package of timing constants and encodings for the flash program/erase host controller.
package fpes_pkg;

  // ---------------------------------------------------------------------------
  // Clock
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;

  // ---------------------------------------------------------------------------
  // Bus timing figures, in their own units
  // ---------------------------------------------------------------------------
  localparam int WRITE_CYCLE_NS    = 70;
  localparam int WRITE_PULSE_NS    = 30;
  localparam int WRITE_HIGH_NS     = 30;
  localparam int OE_HIGH_POLL_NS   = 20;
  localparam int ADDR_SETUP_OE_NS  = 12;
  localparam int READ_ACCESS_NS    = 70;
  localparam int UNPROT_SETUP_US   = 4;
  localparam int UNPROT_HOLD_US    = 4;
  localparam int PROGRAM_MAX_US    = 80;
  localparam int ERASE_MAX_MS      = 5000;

  function automatic int fpes_cycles_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ---------------------------------------------------------------------------
  // Cycle counts derived from the figures
  // ---------------------------------------------------------------------------
  localparam int WP_CYC        = fpes_cycles_min(WRITE_PULSE_NS);
  localparam int WPH_CYC0      = fpes_cycles_min(WRITE_HIGH_NS);
  localparam int WC_REST       = fpes_cycles_min(WRITE_CYCLE_NS) - WP_CYC;
  localparam int WPH_CYC       = (WPH_CYC0 > WC_REST) ? WPH_CYC0 : WC_REST;
  localparam int OEPH_CYC      = fpes_cycles_min(OE_HIGH_POLL_NS);
  localparam int ASO_CYC       = fpes_cycles_min(ADDR_SETUP_OE_NS);
  localparam int RD_CYC        = fpes_cycles_min(READ_ACCESS_NS) + 1;
  localparam int RSP_CYC       = fpes_cycles_min(UNPROT_SETUP_US * 1000);
  localparam int RRB_CYC       = fpes_cycles_min(UNPROT_HOLD_US * 1000);
  localparam int PROG_TO_CYC   = fpes_cycles_min(PROGRAM_MAX_US * 1000);
  localparam int ERASE_TO_CYC  = ERASE_MAX_MS * (1000000 / CLK_PERIOD_NS);

  // ---------------------------------------------------------------------------
  // Field positions and encodings
  // ---------------------------------------------------------------------------
  localparam int ADDR_W          = 21;
  localparam int DATA_W          = 16;
  localparam int POLL_BIT        = 7;
  localparam int TOGGLE_BIT      = 6;
  localparam int ADDR_BIT_SIX    = 6;
  localparam int ADDR_BIT_ONE    = 1;
  localparam int ADDR_BIT_ZERO   = 0;
  localparam int TMO_W           = 32;

  typedef enum logic [1:0]
  {
    FPES_OP_WRITE = 2'h0,
    FPES_OP_READ  = 2'h1,
    FPES_OP_POLL  = 2'h2,
    FPES_OP_PROT  = 2'h3
  } fpes_op_type;

endpackage

// ===== verilog/fpes_tmr_if.sv
// Interface carrying the timer load and expiry between controller and timer.
`timescale 1ns/1ps
`default_nettype none
interface fpes_tmr_if;
  logic                       load;
  logic [fpes_pkg::TMO_W-1:0] value;
  logic                       expired;
  modport ctrl  (output load, output value, input expired);
  modport timer (input load, input value, output expired);
endinterface
`default_nettype wire

// ===== verilog/fpes_timer.sv
// Down-counting timer used for bus phases and settle times; operation timeouts use the host's own tmo_cnt.
`timescale 1ns/1ps
`default_nettype none
module fpes_timer
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  fpes_tmr_if.timer       tmr
);
  logic [fpes_pkg::TMO_W-1:0] count;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      count <= '0;
    else if (tmr.load)
      count <= tmr.value;
    else if (count != '0)
      count <= count - 1'b1;
  end

  // Expiry looks at the count alone, so a phase may reload from its own expiry without a loop.
  assign tmr.expired = (count == '0);
endmodule
`default_nettype wire

// ===== verilog/fpes_host.sv
// Host controller that drives an asynchronous parallel flash bus for write, read and status polling.
// Notes on behaviour
// - A new write may start as soon as ready/busy shows ready.
// - Hold reset elevated at least 4 us before first unprotect write.
// - Keep reset elevated at least 4 us after ready returns when leaving.
// - Successive status reads by output gate flip the toggle bit.
// - Protect cycles drive address bit one high, bit zero low, bit six per mode.
// - Output gate stays high at least 20 ns between status reads.
// - Address is presented at least 12 ns before output gate goes low.
// - Each write cycle lasts at least 70 ns.
// - Write strobe low and high each at least 30 ns.
// - Chip select high between chip-select-controlled pulses at least 30 ns.
`timescale 1ns/1ps
`default_nettype none
module fpes_host
(
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic                          cmd_valid,
  output logic                               cmd_ready,
  input  wire fpes_pkg::fpes_op_type         cmd_op,
  input  wire logic [fpes_pkg::ADDR_W-1:0]   cmd_addr,
  input  wire logic [fpes_pkg::DATA_W-1:0]   cmd_data,
  input  wire logic                          cmd_erase,
  input  wire logic                          cmd_unprotect,
  input  wire logic                          cmd_use_ce,
  input  wire logic                          unprot_req,
  output logic                               done,
  output logic                               timeout,
  output logic [fpes_pkg::DATA_W-1:0]        rd_data,
  output logic                               unprot_active,
  output logic [fpes_pkg::ADDR_W-1:0]        flash_addr,
  input  wire logic [fpes_pkg::DATA_W-1:0]   flash_dq_in,
  output logic [fpes_pkg::DATA_W-1:0]        flash_dq_out,
  output logic                               flash_dq_oe_n,
  output logic                               flash_ce_n,
  output logic                               flash_oe_n,
  output logic                               flash_we_n,
  output logic                               flash_reset_hv,
  input  wire logic                          ready_busy_indicator
);

  // ---------------------------------------------------------------------------
  // State machine
  // ---------------------------------------------------------------------------
  typedef enum logic [9:0]
  {
    S_IDLE   = 10'h001,
    S_WLOW   = 10'h002,
    S_WHIGH  = 10'h004,
    S_ASET   = 10'h008,
    S_RLOW   = 10'h010,
    S_RHIGH  = 10'h020,
    S_UPSET  = 10'h040,
    S_UPHOLD = 10'h080,
    S_UPWAIT = 10'h100,
    S_FINISH = 10'h200
  } fpes_state_type;

  fpes_state_type state;
  fpes_pkg::fpes_op_type op;
  logic           poll_first;
  logic           last_toggle;
  logic           use_ce;
  logic           tmo_armed;
  logic [fpes_pkg::TMO_W-1:0] tmo_cnt;

  fpes_tmr_if tmr ();

  fpes_timer u_timer
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .tmr     (tmr)
  );

  function automatic logic [fpes_pkg::TMO_W-1:0] fpes_ld(input int cyc);
    return fpes_pkg::TMO_W'(cyc - 1);
  endfunction

  assign cmd_ready     = (state == S_IDLE) && ready_busy_indicator;
  assign unprot_active = flash_reset_hv;

  // ---------------------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= S_IDLE;
      op    <= fpes_pkg::FPES_OP_WRITE;
    end
    else
    begin
      unique case (state)
        S_IDLE:
        begin
          if (unprot_req && !flash_reset_hv)
            state <= S_UPSET;
          else if (!unprot_req && flash_reset_hv && ready_busy_indicator)
            state <= S_UPHOLD;
          else if (cmd_valid && cmd_ready)
          begin
            op <= cmd_op;
            if (cmd_op == fpes_pkg::FPES_OP_WRITE || cmd_op == fpes_pkg::FPES_OP_PROT)
              state <= S_WLOW;
            else
              state <= S_ASET;
          end
        end
        S_WLOW:   if (tmr.expired) state <= S_WHIGH;
        S_WHIGH:  if (tmr.expired) state <= S_FINISH;
        S_ASET:   if (tmr.expired) state <= S_RLOW;
        S_RLOW:   if (tmr.expired) state <= S_RHIGH;
        S_RHIGH:
        begin
          if (tmr.expired)
          begin
            if (op != fpes_pkg::FPES_OP_POLL || poll_first)
              state <= S_ASET;
            else if (flash_dq_in[fpes_pkg::TOGGLE_BIT] == last_toggle || timeout)
              state <= S_FINISH;
            else
              state <= S_ASET;
          end
        end
        S_UPSET:  if (tmr.expired) state <= S_FINISH;
        S_UPHOLD: if (tmr.expired) state <= S_FINISH;
        S_UPWAIT: state <= S_FINISH;
        S_FINISH: state <= S_IDLE;
        default:  state <= S_IDLE;
      endcase
      if (state == S_RHIGH && tmr.expired && op == fpes_pkg::FPES_OP_READ)
        state <= S_FINISH;
    end
  end

  // ---------------------------------------------------------------------------
  // Phase timer loads
  // ---------------------------------------------------------------------------
  always_comb
  begin
    tmr.load  = 1'b0;
    tmr.value = '0;
    unique case (state)
      S_IDLE:
      begin
        if (unprot_req && !flash_reset_hv)
        begin
          tmr.load  = 1'b1;
          tmr.value = fpes_ld(fpes_pkg::RSP_CYC);
        end
        else if (!unprot_req && flash_reset_hv && ready_busy_indicator)
        begin
          tmr.load  = 1'b1;
          tmr.value = fpes_ld(fpes_pkg::RRB_CYC);
        end
        else if (cmd_valid && cmd_ready)
        begin
          tmr.load  = 1'b1;
          if (cmd_op == fpes_pkg::FPES_OP_WRITE || cmd_op == fpes_pkg::FPES_OP_PROT)
            tmr.value = fpes_ld(fpes_pkg::WP_CYC);
          else
            tmr.value = fpes_ld(fpes_pkg::ASO_CYC);
        end
      end
      S_WLOW:
      begin
        tmr.load  = tmr.expired;
        tmr.value = fpes_ld(fpes_pkg::WPH_CYC);
      end
      S_ASET:
      begin
        tmr.load  = tmr.expired;
        tmr.value = fpes_ld(fpes_pkg::RD_CYC);
      end
      S_RLOW:
      begin
        tmr.load  = tmr.expired;
        tmr.value = fpes_ld(fpes_pkg::OEPH_CYC);
      end
      S_RHIGH:
      begin
        tmr.load  = tmr.expired;
        tmr.value = fpes_ld(fpes_pkg::ASO_CYC);
      end
      default:
      begin
        tmr.load  = 1'b0;
        tmr.value = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Bus pins
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      flash_addr    <= '0;
      flash_dq_out  <= '0;
      use_ce        <= 1'b0;
    end
    else if (state == S_IDLE && cmd_valid && cmd_ready)
    begin
      flash_addr   <= cmd_addr;
      flash_dq_out <= cmd_data;
      use_ce       <= cmd_use_ce;
      if (cmd_op == fpes_pkg::FPES_OP_PROT)
      begin
        flash_addr[fpes_pkg::ADDR_BIT_ONE]  <= 1'b1;
        flash_addr[fpes_pkg::ADDR_BIT_ZERO] <= 1'b0;
        flash_addr[fpes_pkg::ADDR_BIT_SIX]  <= cmd_unprotect;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      flash_ce_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_dq_oe_n <= 1'b1;
    end
    else
    begin
      // The strobe that is not pulsing is held low so that the other one times the cycle.
      flash_dq_oe_n <= !(state == S_WLOW || state == S_WHIGH);
      flash_we_n    <= !(state == S_WLOW && !use_ce) && !((state == S_WLOW || state == S_WHIGH) && use_ce);
      flash_ce_n    <= !(state == S_ASET || state == S_RLOW || state == S_RHIGH
                         || (state == S_WLOW) || (state == S_WHIGH && !use_ce));
      flash_oe_n    <= !(state == S_RLOW);
    end
  end

  // ---------------------------------------------------------------------------
  // Status capture and results
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data     <= '0;
      last_toggle <= 1'b0;
      poll_first  <= 1'b0;
    end
    else if (state == S_IDLE)
      poll_first <= 1'b1;
    else if (state == S_RHIGH && tmr.expired)
    begin
      rd_data     <= flash_dq_in;
      last_toggle <= flash_dq_in[fpes_pkg::TOGGLE_BIT];
      poll_first  <= 1'b0;
    end
  end

  // Timeout covers the whole poll; the longer erase bound is used when requested.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tmo_cnt   <= '0;
      tmo_armed <= 1'b0;
      timeout   <= 1'b0;
    end
    else if (state == S_IDLE && cmd_valid && cmd_ready)
    begin
      tmo_cnt   <= cmd_erase ? fpes_pkg::TMO_W'(fpes_pkg::ERASE_TO_CYC)
                             : fpes_pkg::TMO_W'(fpes_pkg::PROG_TO_CYC);
      tmo_armed <= (cmd_op == fpes_pkg::FPES_OP_POLL);
      timeout   <= 1'b0;
    end
    else if (tmo_armed && tmo_cnt != '0)
      tmo_cnt <= tmo_cnt - 1'b1;
    else if (tmo_armed)
    begin
      timeout   <= 1'b1;
      tmo_armed <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      done <= 1'b0;
    else
      done <= (state == S_FINISH);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      flash_reset_hv <= 1'b0;
    else if (state == S_UPSET)
      flash_reset_hv <= 1'b1;
    else if (state == S_UPHOLD && tmr.expired)
      flash_reset_hv <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  logic [7:0] oeh_cnt;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      oeh_cnt <= 8'hFF;
    else if (!flash_oe_n)
      oeh_cnt <= 8'h00;
    else if (oeh_cnt != 8'hFF)
      oeh_cnt <= oeh_cnt + 8'h01;
  end

  oe_gap_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(flash_oe_n) |-> $past(oeh_cnt) >= 8'h01)
    else $error("output gate high too short");
  we_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(flash_we_n) |=> flash_we_n)
    else $error("write strobe high too short");
  prot_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
    (op == fpes_pkg::FPES_OP_PROT && state == S_WLOW) |->
      flash_addr[fpes_pkg::ADDR_BIT_ONE] && !flash_addr[fpes_pkg::ADDR_BIT_ZERO])
    else $error("protect address encoding wrong");
  start_ready_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(flash_ce_n) |-> $past(ready_busy_indicator, 2))
    else $error("command taken while busy");
  done_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
    $past(state) == S_FINISH |-> done)
    else $error("done not pulsed after finish");
  addr_setup_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(flash_oe_n) |-> $stable(flash_addr))
    else $error("address changed at output gate fall");

endmodule
`default_nettype wire

// ===== verification/fpes_flash_model.sv
// Behavioural model of the parallel flash device on the far side of the host controller.
`timescale 1ns/1ps
`default_nettype none
module fpes_flash_model
#(
  parameter int PROG_NS  = 6000,
  parameter int ERASE_NS = 500000000
)
(
  input  wire logic [fpes_pkg::ADDR_W-1:0] addr,
  input  wire logic [fpes_pkg::DATA_W-1:0] dq_out,
  input  wire logic                        dq_oe_n,
  input  wire logic                        ce_n,
  input  wire logic                        oe_n,
  input  wire logic                        we_n,
  input  wire logic                        reset_hv,
  input  wire logic                        hang,
  input  wire logic                        erase_mode,
  output logic [fpes_pkg::DATA_W-1:0]      dq_in,
  output logic                             ready_busy,
  output logic [15:0]                      viol,
  output logic [fpes_pkg::ADDR_W-1:0]      last_waddr
);
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [15:0] mem [logic [20:0]];
  logic [15:0] wdata, rd_word, drv_val, held;
  logic        busy, tog, sus, driven, upd;
  realtime     t_start, t_end, t_oe_rise, t_addr, t_hv_rise, t_rdy_rise;
  wire         wr_act = !we_n && !ce_n;

  initial
  begin
    busy = 1'b0; tog = 1'b0; sus = 1'b0; upd = 1'b0; held = 16'h5A5A;
    ready_busy = 1'b1; viol = 16'h0000; last_waddr = '0; wdata = 16'h0000;
    t_start = -1.0e9; t_end = -1.0e9; t_oe_rise = -1.0e9; t_addr = -1.0e9;
    t_hv_rise = -1.0e9; t_rdy_rise = -1.0e9;
  end

  // ---------------------------------------------------------------------------
  // Reads and bus
  // ---------------------------------------------------------------------------
  // No sector is ever erase-suspended here, so the suspend toggle bit stays put.
  always @(addr, busy, tog, upd, wdata)
    rd_word = busy ? {8'h00, ~wdata[7], tog, 3'b000, sus, 2'b00}
                   : (mem.exists(addr) ? mem[addr] : 16'hFFFF);

  // A released bus shows the inverse of its last level, never a stale copy.
  always @*
  begin
    driven  = !dq_oe_n || (!ce_n && !oe_n);
    drv_val = !dq_oe_n ? dq_out : rd_word;
    if (driven)
      held = drv_val;
  end
  assign dq_in = driven ? drv_val : ~held;

  always @(addr) t_addr = $realtime;
  always @(posedge oe_n) t_oe_rise = $realtime;
  always @(posedge reset_hv) t_hv_rise = $realtime;
  always @(negedge reset_hv)
    if ($realtime > 1.0 && $realtime - t_rdy_rise < 4000.0) viol++;

  always @(negedge oe_n, negedge ce_n)
    if (!oe_n && !ce_n && we_n && busy)
    begin
      if ($realtime - t_oe_rise < 20.0) viol++;
      if ($realtime - t_addr < 12.0) viol++;
      tog = ~tog;
    end

  // ---------------------------------------------------------------------------
  // Writes and embedded algorithm
  // ---------------------------------------------------------------------------
  always @(posedge wr_act)
    if ($realtime > 1.0)
    begin
      if ($realtime - t_start < 70.0) viol++;
      if ($realtime - t_end < 30.0) viol++;
      if (reset_hv && $realtime - t_hv_rise < 4000.0) viol++;
      t_start = $realtime;
    end

  // The hang input keeps the algorithm running while ready is wrongly shown.
  always @(negedge wr_act)
    if ($realtime > 1.0)
    begin : run
      logic [20:0] a;
      logic        er;
      if ($realtime - t_start < 30.0) viol++;
      t_end = $realtime;
      a = addr;
      er = erase_mode;
      wdata = dq_out;
      last_waddr = addr;
      if (er) mem[a] = 16'h0000;
      busy = 1'b1;
      #10;
      ready_busy = hang;
      #((er ? ERASE_NS : PROG_NS) - 10);
      wait (!hang);
      mem[a] = er ? 16'hFFFF : wdata;
      upd = ~upd;
      busy = 1'b0;
      ready_busy = 1'b1;
      t_rdy_rise = $realtime;
    end
endmodule
`default_nettype wire

// ===== verification/flash_program_erase_status_tb.sv
// Self-checking testbench for the flash program/erase host controller.
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_status_tb;
  // ---------------------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------------------
  logic                        sys_clk, rst, cmd_valid, cmd_ready;
  fpes_pkg::fpes_op_type       cmd_op;
  logic [fpes_pkg::ADDR_W-1:0] cmd_addr, flash_addr, last_waddr;
  logic [fpes_pkg::DATA_W-1:0] cmd_data, rd_data, flash_dq_in, flash_dq_out;
  logic                        cmd_erase, cmd_unprotect, cmd_use_ce, unprot_req, done, timeout;
  logic                        unprot_active, flash_dq_oe_n, flash_ce_n, flash_oe_n, flash_we_n;
  logic                        flash_reset_hv, ready_busy_indicator, hang, erase_mode;
  logic [15:0]                 viol;
  int                          miscompares, cmp_count;

  fpes_host dut (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_erase(cmd_erase),
    .cmd_unprotect(cmd_unprotect), .cmd_use_ce(cmd_use_ce), .unprot_req(unprot_req), .done(done),
    .timeout(timeout), .rd_data(rd_data), .unprot_active(unprot_active), .flash_addr(flash_addr),
    .flash_dq_in(flash_dq_in), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_reset_hv(flash_reset_hv), .ready_busy_indicator(ready_busy_indicator));

  // Erase is shortened in the model only; the controller keeps its own long limit.
  fpes_flash_model #(.PROG_NS(6000), .ERASE_NS(20000)) flash (.addr(flash_addr),
    .dq_out(flash_dq_out), .dq_oe_n(flash_dq_oe_n), .ce_n(flash_ce_n), .oe_n(flash_oe_n),
    .we_n(flash_we_n), .reset_hv(flash_reset_hv), .hang(hang), .erase_mode(erase_mode),
    .dq_in(flash_dq_in), .ready_busy(ready_busy_indicator), .viol(viol), .last_waddr(last_waddr));

  always #20 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk_bit(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wait_done(input int lim);
    int n;
    n = 0;
    while (done !== 1'b1 && n < lim)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk_bit("done", 1'b1, done);
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    while (ready_busy_indicator !== 1'b1 && n < 2000)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk_bit("cmd_ready", 1'b1, cmd_ready);
  endtask

  task automatic issue(input fpes_pkg::fpes_op_type op, input logic [20:0] a, input logic [15:0] d,
                       input logic er, input logic un, input logic ce, input int lim);
    int n;
    @(negedge sys_clk);
    cmd_op = op; cmd_addr = a; cmd_data = d; cmd_erase = er; cmd_unprotect = un; cmd_use_ce = ce;
    cmd_valid = 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 1000)
    begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    wait_done(lim);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    chk_bit("we_n", 1'b1, flash_we_n);
    chk_bit("ce_n", 1'b1, flash_ce_n);
    chk_bit("oe_n", 1'b1, flash_oe_n);
    chk_bit("reset_hv", 1'b0, flash_reset_hv);
    chk_bit("cmd_ready", ready_busy_indicator, cmd_ready);
  endtask

  task automatic t_write_read;
    issue(fpes_pkg::FPES_OP_WRITE, 21'h000100, 16'h1234, 1'b0, 1'b0, 1'b0, 20);
    chk_bit("cmd_ready", 1'b0, cmd_ready);
    wait_ready;
    issue(fpes_pkg::FPES_OP_WRITE, 21'h100200, 16'hBEEF, 1'b0, 1'b0, 1'b1, 20);
    wait_ready;
    issue(fpes_pkg::FPES_OP_READ, 21'h000100, 16'h0000, 1'b0, 1'b0, 1'b0, 40);
    chk_word("rd_data", 16'h1234, rd_data);
    issue(fpes_pkg::FPES_OP_READ, 21'h100200, 16'h0000, 1'b0, 1'b0, 1'b0, 40);
    chk_word("rd_data", 16'hBEEF, rd_data);
  endtask

  task automatic t_erase_poll;
    erase_mode = 1'b1;
    issue(fpes_pkg::FPES_OP_WRITE, 21'h040000, 16'h0030, 1'b0, 1'b0, 1'b0, 20);
    erase_mode = 1'b0;
    wait_ready;
    issue(fpes_pkg::FPES_OP_POLL, 21'h040000, 16'h0000, 1'b1, 1'b0, 1'b0, 300);
    chk_bit("timeout", 1'b0, timeout);
    chk_word("rd_data", 16'hFFFF, rd_data);
  endtask

  task automatic t_protect;
    for (int u = 0; u < 2; u++)
    begin
      issue(fpes_pkg::FPES_OP_PROT, u[0] ? 21'h000001 : 21'h000041, 16'h0060, 1'b0, u[0], 1'b0, 20);
      chk_bit("addr1", 1'b1, last_waddr[1]);
      chk_bit("addr0", 1'b0, last_waddr[0]);
      chk_bit("addr6", u[0], last_waddr[6]);
      wait_ready;
    end
  endtask

  task automatic t_unprotect;
    @(negedge sys_clk);
    unprot_req = 1'b1;
    wait_done(300);
    chk_bit("unprot_active", 1'b1, unprot_active);
    issue(fpes_pkg::FPES_OP_WRITE, 21'h000300, 16'h0F0F, 1'b0, 1'b0, 1'b0, 20);
    wait_ready;
    @(negedge sys_clk);
    unprot_req = 1'b0;
    wait_done(300);
    chk_bit("unprot_active", 1'b0, unprot_active);
  endtask

  task automatic t_hang;
    logic [15:0] s0;
    hang = 1'b1;
    issue(fpes_pkg::FPES_OP_WRITE, 21'h000400, 16'h00A5, 1'b0, 1'b0, 1'b0, 20);
    issue(fpes_pkg::FPES_OP_READ, 21'h000400, 16'h0000, 1'b0, 1'b0, 1'b0, 40);
    s0 = rd_data;
    chk_bit("poll_bit", 1'b0, s0[7]);
    issue(fpes_pkg::FPES_OP_READ, 21'h000400, 16'h0000, 1'b0, 1'b0, 1'b0, 40);
    chk_bit("toggle_bit", ~s0[6], rd_data[6]);
    issue(fpes_pkg::FPES_OP_POLL, 21'h000400, 16'h0000, 1'b0, 1'b0, 1'b0, fpes_pkg::PROG_TO_CYC + 600);
    chk_bit("timeout", 1'b1, timeout);
    hang = 1'b0;
    wait_ready;
    issue(fpes_pkg::FPES_OP_READ, 21'h000400, 16'h0000, 1'b0, 1'b0, 1'b0, 40);
    chk_bit("timeout", 1'b0, timeout);
    chk_word("rd_data", 16'h00A5, rd_data);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0; rst = 1'b1; cmd_valid = 1'b0; cmd_op = fpes_pkg::FPES_OP_WRITE;
    cmd_addr = '0; cmd_data = 16'h0000; cmd_erase = 1'b0; cmd_unprotect = 1'b0; cmd_use_ce = 1'b0;
    unprot_req = 1'b0; hang = 1'b0; erase_mode = 1'b0; miscompares = 0; cmp_count = 0;
    repeat (6) @(negedge sys_clk);
    t_reset;
    rst = 1'b0;
    t_write_read;
    t_erase_poll;
    t_protect;
    t_unprotect;
    t_hang;
    chk_word("violations", 16'h0000, viol);
    stop_test;
  end

  // Worst path is the stuck poll at about 2,000 cycles; the rest stays under 3,000.
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    stop_test;
  end
endmodule
`default_nettype wire
